// ===== verilog/fdc_pkg.sv
`default_nettype none
package fdc_pkg;
	localparam int NUM_CH = 4;
	localparam int CNT_W  = 14;

	// control register field positions
	localparam int CTL_ON_BIT    = 15;
	localparam int CTL_SIZE_BIT  = 14;
	localparam int CTL_DIR_BIT   = 13;
	localparam int CTL_HALF_BIT  = 12;
	localparam int CTL_NULL_WRITE_SELECT_BIT = 11;
	localparam int CTL_ADDRESSING_SELECT_LO  = 4;
	localparam int CTL_MODE_LO   = 0;
	localparam logic [15:0] CTL_WR_MASK = 16'hf833;

	// addressing_select codes
	localparam logic [1:0] AM_POSTINC = 2'b00;
	localparam logic [1:0] AM_NOINC   = 2'b01;
	localparam logic [1:0] AM_PERIPH  = 2'b10;
	localparam logic [1:0] AM_RSVD    = 2'b11;
	// operating mode bits: bit0 one-shot, bit1 ping-pong
	localparam int MODE_ONESHOT_BIT  = 0;
	localparam int MODE_PINGPONG_BIT = 1;

	// register map: byte address bits 7 global, 6:5 channel, 4:2 register
	localparam logic [2:0] REG_CTL  = 3'h0;
	localparam logic [2:0] REG_SEL  = 3'h1;
	localparam logic [2:0] REG_RAMA = 3'h2;
	localparam logic [2:0] REG_RAMB = 3'h3;
	localparam logic [2:0] REG_PAD  = 3'h4;
	localparam logic [2:0] REG_CNT  = 3'h5;
	localparam logic [2:0] GLB_FORCE  = 3'h0;
	localparam logic [2:0] GLB_STATUS = 3'h1;

	// reset values
	localparam logic [15:0] RST_CTL = 16'h0000;
	localparam logic [15:0] RST_PAD = 16'h0000;
	localparam logic [13:0] RST_CNT = 14'h0000;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_READ  = 2'b01,
		ST_WRITE = 2'b10,
		ST_NULL  = 2'b11
	} fdc_state_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        byteSel;
		logic [15:0] addr;
		logic [15:0] data;
	} fdc_xfer_t;

	typedef struct packed {
		logic [NUM_CH-1:0][15:0]      ctl;
		logic [NUM_CH-1:0][7:0]       sel;
		logic [NUM_CH-1:0][15:0]      ramA;
		logic [NUM_CH-1:0][15:0]      ramB;
		logic [NUM_CH-1:0][15:0]      pad;
		logic [NUM_CH-1:0][CNT_W-1:0] cnt;
		logic [NUM_CH-1:0][CNT_W-1:0] done;
		logic [NUM_CH-1:0]            pend;
		logic [NUM_CH-1:0]            pingSel;
		logic [NUM_CH-1:0]            irq;
		logic [1:0]                   cur;
		fdc_state_t                   state;
		logic [15:0]                  data;
		logic                         busAck;
		logic [31:0]                  rdata;
		fdc_xfer_t                    xfer;
	} fdc_regs_t;
endpackage
`default_nettype wire

// ===== verilog/fdc_dma_ctrl.sv
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module fdc_dma_ctrl (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         reset_n,
	// register slave
	input  wire logic [7:0]   avs_address,
	input  wire logic         avs_read,
	input  wire logic         avs_write,
	input  wire logic [31:0]  avs_writedata,
	input  wire logic [3:0]   avs_byteenable,
	output logic      [31:0]  avs_readdata,
	output logic              avs_waitrequest,
	// request sources
	input  wire logic [255:0] irqEvent,
	input  wire logic [15:0]  periphIndirectAddr,
	// data master
	output logic              memValid,
	output logic              memWrite,
	output logic              memByte,
	output logic      [15:0]  memAddr,
	output logic      [15:0]  memWdata,
	input  wire logic         memReady,
	input  wire logic [15:0]  memRdata,
	// block events
	output logic      [3:0]   blockIrq
);
	fdc_pkg::fdc_regs_t q;
	fdc_pkg::fdc_regs_t n;

	logic [3:0]  elig;
	logic [3:0]  evt;
	logic [3:0]  forceHit;
	logic [1:0]  pick;
	logic [1:0]  rdx;
	logic [15:0] ramAddr;
	logic [15:0] padAddr;
	logic [15:0] ctlR;
	logic        elemEnd;
	logic        blockEnd;
	logic        wrAck;
	logic [1:0]  wch;
	logic [15:0] wmerge;

	function automatic logic [1:0] firstCh(input logic [3:0] v);
		logic [1:0] r;
		r = 2'd0;
		for (int i = fdc_pkg::NUM_CH - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = i[1:0];
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	function automatic fdc_pkg::fdc_xfer_t mkReq(input logic wr,
		input logic [15:0] a, input logic [15:0] d, input logic bs);
		fdc_pkg::fdc_xfer_t x;
		x.valid   = 1'b1;
		x.write   = wr;
		x.byteSel = bs;
		x.addr    = a;
		x.data    = d;
		return x;
	endfunction

	function automatic logic [31:0] regRead(input fdc_pkg::fdc_regs_t r,
		input logic [7:0] a);
		logic [31:0] d;
		logic [1:0]  c;
		d = 32'h0;
		c = a[6:5];
		if (a[7]) begin
			if (a[4:2] == fdc_pkg::GLB_STATUS) begin
				d = {23'h0, r.state != fdc_pkg::ST_IDLE, r.pingSel, r.pend};
			end
		end else begin
			case (a[4:2])
				fdc_pkg::REG_CTL:  d = {16'h0, r.ctl[c]};
				fdc_pkg::REG_SEL:  d = {24'h0, r.sel[c]};
				fdc_pkg::REG_RAMA: d = {16'h0, r.ramA[c]};
				fdc_pkg::REG_RAMB: d = {16'h0, r.ramB[c]};
				fdc_pkg::REG_PAD:  d = {16'h0, r.pad[c]};
				fdc_pkg::REG_CNT:  d = {18'h0, r.cnt[c]};
				default:           d = 32'h0;
			endcase
		end
		return d;
	endfunction

	// request qualification per channel
	genvar g;
	generate
		for (g = 0; g < fdc_pkg::NUM_CH; g++) begin : gCh
			// any interrupt source, timers and external pins included
			assign evt[g] = q.ctl[g][fdc_pkg::CTL_ON_BIT]
				&& (irqEvent[q.sel[g]] || forceHit[g]);
			assign elig[g] = q.pend[g] && q.ctl[g][fdc_pkg::CTL_ON_BIT];
		end
	endgenerate

	assign wrAck = avs_write && q.busAck;
	assign forceHit = (wrAck && avs_address[7]
		&& avs_address[4:2] == fdc_pkg::GLB_FORCE && avs_byteenable[0])
		? avs_writedata[3:0] : 4'h0;
	assign wch = avs_address[6:5];
	assign wmerge = merge16(16'h0, avs_writedata, avs_byteenable);

	// lowest number wins; others keep their pending bit
	assign pick = firstCh(elig);
	assign rdx = (q.state == fdc_pkg::ST_IDLE) ? pick : q.cur;
	assign ctlR = q.ctl[rdx];
	assign padAddr = q.pad[rdx];

	always_comb begin
		logic [15:0] base;
		base = q.pingSel[rdx] ? q.ramB[rdx] : q.ramA[rdx];
		case (ctlR[fdc_pkg::CTL_ADDRESSING_SELECT_LO +: 2])
			fdc_pkg::AM_POSTINC: ramAddr = ctlR[fdc_pkg::CTL_SIZE_BIT]
				? base + {2'b00, q.done[rdx]}
				: base + {1'b0, q.done[rdx], 1'b0};
			fdc_pkg::AM_PERIPH:  ramAddr = periphIndirectAddr;
			default:             ramAddr = base; // reserved acts as no-inc
		endcase
	end

	always_comb begin
		logic [1:0]  c;
		logic [15:0] cr;
		n        = q;
		n.irq    = 4'h0;
		n.busAck = 1'b0;
		elemEnd  = 1'b0;
		blockEnd = 1'b0;
		c        = q.cur;
		cr       = q.ctl[q.cur];
		case (q.state)
			fdc_pkg::ST_IDLE: begin
				if (|elig) begin
					n.cur = pick;
					n.pend[pick] = 1'b0;
					n.state = fdc_pkg::ST_READ;
					// one fixed direction per channel
					n.xfer = mkReq(1'b0,
						ctlR[fdc_pkg::CTL_DIR_BIT] ? ramAddr : padAddr,
						16'h0, ctlR[fdc_pkg::CTL_SIZE_BIT]);
				end
			end
			fdc_pkg::ST_READ: begin
				if (memReady) begin
					n.data = cr[fdc_pkg::CTL_SIZE_BIT]
						? {8'h00, memRdata[7:0]} : memRdata;
					n.state = fdc_pkg::ST_WRITE;
					n.xfer = mkReq(1'b1,
						cr[fdc_pkg::CTL_DIR_BIT] ? padAddr : ramAddr,
						n.data, cr[fdc_pkg::CTL_SIZE_BIT]);
				end
			end
			fdc_pkg::ST_WRITE: begin
				if (memReady) begin
					if (cr[fdc_pkg::CTL_NULL_WRITE_SELECT_BIT]
						&& !cr[fdc_pkg::CTL_DIR_BIT]) begin
						n.state = fdc_pkg::ST_NULL;
						n.xfer = mkReq(1'b1, padAddr, 16'h0,
							cr[fdc_pkg::CTL_SIZE_BIT]);
					end else begin
						elemEnd = 1'b1;
					end
				end
			end
			fdc_pkg::ST_NULL: begin
				if (memReady) begin
					elemEnd = 1'b1;
				end
			end
			default: begin
				n.state = fdc_pkg::ST_IDLE;
			end
		endcase

		if (elemEnd) begin
			n.state = fdc_pkg::ST_IDLE;
			n.xfer.valid = 1'b0;
			// interrupt at half or full block
			n.irq[c] = cr[fdc_pkg::CTL_HALF_BIT]
				? (q.done[c] == (q.cnt[c] >> 1))
				: (q.done[c] == q.cnt[c]);
			if (q.done[c] == q.cnt[c]) begin
				// count plus one elements make a block
				blockEnd = 1'b1;
				n.done[c] = '0;
				if (cr[fdc_pkg::MODE_PINGPONG_BIT]) begin
					n.pingSel[c] = !q.pingSel[c];
				end
				// one-shot ping-pong stops after the second buffer
				if (cr[fdc_pkg::MODE_ONESHOT_BIT]
					&& (!cr[fdc_pkg::MODE_PINGPONG_BIT] || q.pingSel[c])) begin
					n.ctl[c][fdc_pkg::CTL_ON_BIT] = 1'b0;
				end
			end else begin
				n.done[c] = q.done[c] + 14'h0001;
			end
		end

		// register slave: one wait cycle, then answer
		if ((avs_read || avs_write) && !q.busAck) begin
			n.busAck = 1'b1;
			n.rdata = regRead(q, avs_address);
		end
		if (wrAck && !avs_address[7]) begin
			case (avs_address[4:2])
				fdc_pkg::REG_CTL: begin
					n.ctl[wch] = merge16(q.ctl[wch], avs_writedata,
						avs_byteenable) & fdc_pkg::CTL_WR_MASK;
					if (!wmerge[fdc_pkg::CTL_ON_BIT] && avs_byteenable[1]) begin
						n.done[wch] = '0;
						n.pingSel[wch] = 1'b0;
					end
				end
				fdc_pkg::REG_SEL: begin
					if (avs_byteenable[0]) begin
						n.sel[wch] = avs_writedata[7:0];
					end
				end
				fdc_pkg::REG_RAMA: begin
					n.ramA[wch] = merge16(q.ramA[wch], avs_writedata,
						avs_byteenable);
				end
				fdc_pkg::REG_RAMB: begin
					n.ramB[wch] = merge16(q.ramB[wch], avs_writedata,
						avs_byteenable);
				end
				fdc_pkg::REG_PAD: begin
					n.pad[wch] = merge16(q.pad[wch], avs_writedata,
						avs_byteenable);
				end
				fdc_pkg::REG_CNT: begin
					n.cnt[wch] = 14'(merge16({2'b00, q.cnt[wch]},
						avs_writedata, avs_byteenable) & 16'h3fff);
				end
				default: begin
				end
			endcase
		end

		// set wins over grant clear; off channels drop requests
		for (int i = 0; i < fdc_pkg::NUM_CH; i++) begin
			if (evt[i]) begin
				n.pend[i] = 1'b1;
			end
			if (!n.ctl[i][fdc_pkg::CTL_ON_BIT]) begin
				n.pend[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			q <= '0;
			for (int i = 0; i < fdc_pkg::NUM_CH; i++) begin
				q.ctl[i] <= fdc_pkg::RST_CTL;
				q.pad[i] <= fdc_pkg::RST_PAD;
				q.cnt[i] <= fdc_pkg::RST_CNT;
			end
			q.state <= fdc_pkg::ST_IDLE;
		end else begin
			q <= n;
		end
	end

	assign avs_waitrequest = (avs_read || avs_write) && !q.busAck;
	assign avs_readdata    = q.rdata;
	assign memValid        = q.xfer.valid;
	assign memWrite        = q.xfer.write;
	assign memByte         = q.xfer.byteSel;
	assign memAddr         = q.xfer.addr;
	assign memWdata        = q.xfer.data;
	assign blockIrq        = q.irq;

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	logic [3:0] lowerElig;
	assign lowerElig = elig & (elig - 4'h1) ^ elig;

	prio_grant_a: assert property (
		q.state == fdc_pkg::ST_IDLE && |elig
		|=> q.cur == $past(pick)
			&& $past(lowerElig) == (4'h1 << q.cur)
			&& ($past(elig) & ~$past(lowerElig)
			& ~q.pend) == 4'h0)
		else $error("grant not to lowest pending channel");

	loser_pending_a: assert property (
		q.state == fdc_pkg::ST_IDLE && elig[0] && elig[1]
		|=> q.cur == 2'd0 && q.pend[1])
		else $error("losing channel lost its request");

	ram_dir_a: assert property (
		q.state == fdc_pkg::ST_READ && memValid
		&& q.ctl[q.cur][fdc_pkg::CTL_DIR_BIT] == 1'b0
		|-> memAddr == q.pad[q.cur] && !memWrite)
		else $error("peripheral not source with direction clear");

	byte_step_a: assert property (
		q.state == fdc_pkg::ST_READ && memReady
		&& q.ctl[q.cur][fdc_pkg::CTL_SIZE_BIT]
		|=> memWdata[15:8] == 8'h00 && memByte)
		else $error("byte transfer carried a high byte");

	null_write_a: assert property (
		q.state == fdc_pkg::ST_WRITE && memReady
		&& q.ctl[q.cur][fdc_pkg::CTL_NULL_WRITE_SELECT_BIT]
		&& !q.ctl[q.cur][fdc_pkg::CTL_DIR_BIT]
		|=> q.state == fdc_pkg::ST_NULL && memWrite
		&& memWdata == 16'h0000 && memAddr == $past(q.pad[q.cur]))
		else $error("missing null peripheral write");

	full_irq_a: assert property (
		elemEnd && !q.ctl[q.cur][fdc_pkg::CTL_HALF_BIT]
		&& q.done[q.cur] == q.cnt[q.cur]
		|=> blockIrq == (4'h1 << $past(q.cur)) ##1 blockIrq == 4'h0)
		else $error("block end without single interrupt pulse");

	half_irq_a: assert property (
		elemEnd && q.ctl[q.cur][fdc_pkg::CTL_HALF_BIT]
		&& q.done[q.cur] != (q.cnt[q.cur] >> 1)
		|=> blockIrq == 4'h0)
		else $error("half mode interrupt at wrong element");

	ping_swap_a: assert property (
		blockEnd && q.ctl[q.cur][fdc_pkg::MODE_PINGPONG_BIT]
		|=> q.pingSel[$past(q.cur)] != $past(q.pingSel[q.cur]))
		else $error("ping-pong buffer not swapped");

	oneshot_off_a: assert property (
		blockEnd && q.ctl[q.cur][fdc_pkg::MODE_ONESHOT_BIT]
		&& !q.ctl[q.cur][fdc_pkg::MODE_PINGPONG_BIT] && !wrAck
		|=> !q.ctl[$past(q.cur)][fdc_pkg::CTL_ON_BIT])
		else $error("one-shot channel still enabled");

	cnt_top_a: assert property (
		avs_read && !avs_waitrequest && !avs_address[7]
		&& avs_address[4:2] == fdc_pkg::REG_CNT
		|-> avs_readdata[31:14] == 18'h0)
		else $error("count upper bits not zero");

	off_idle_a: assert property (
		!q.ctl[0][fdc_pkg::CTL_ON_BIT] |-> !q.pend[0])
		else $error("disabled channel holds a request");

	bus_answer_a: assert property (
		(avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
		else $error("register access not answered in two cycles");

	c_block_c: cover property (blockEnd ##[1:50] blockEnd);
	c_pingpong_c: cover property (blockEnd && q.pingSel[q.cur]);
	c_contend_c: cover property (q.state == fdc_pkg::ST_IDLE
		&& elig[0] && elig[3]);
	c_null_c: cover property (q.state == fdc_pkg::ST_NULL && memReady);
endmodule
`default_nettype wire

// ===== test/fdc_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module fdc_mem_model (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// data slave
	input  wire logic        memValid,
	input  wire logic        memWrite,
	input  wire logic        memByte,
	input  wire logic [15:0] memAddr,
	input  wire logic [15:0] memWdata,
	output logic             memReady,
	output logic      [15:0] memRdata,
	// wait cycles per phase
	input  wire logic [1:0]  slow
);
	logic [15:0] mem [0:4095];
	logic [15:0] wrLog [$];
	logic [1:0]  waitCnt;
	logic [15:0] lastRd = 16'h0000;
	// ready can come in the first cycle, or after slow waits
	assign memReady = memValid && waitCnt == slow;
	// idle bus shows the inverse of the last word, never a stale copy
	assign memRdata = (memValid && !memWrite) ? mem[memAddr[12:1]] : ~lastRd;
	always @(posedge clk_sys) begin
		if (!reset_n || memReady || !memValid)
			waitCnt <= 2'h0;
		else
			waitCnt <= waitCnt + 2'h1;
		if (memReady && !memWrite)
			lastRd <= mem[memAddr[12:1]];
		if (memReady && memWrite) begin
			wrLog.push_back(memAddr);
			if (!memByte)
				mem[memAddr[12:1]] <= memWdata;
			else if (memAddr[0])
				mem[memAddr[12:1]][15:8] <= memWdata[7:0];
			else
				mem[memAddr[12:1]][7:0] <= memWdata[7:0];
		end
	end
endmodule
`default_nettype wire

// ===== test/four_channel_dma_controller_bench.sv
`timescale 1ns/1ns
`default_nettype none
module four_channel_dma_controller_bench;
	logic         clk_sys = 1'b0;
	logic         reset_n;
	logic [7:0]   avs_address;
	logic         avs_read;
	logic         avs_write;
	logic [31:0]  avs_writedata;
	logic [3:0]   avs_byteenable;
	logic [31:0]  avs_readdata;
	logic         avs_waitrequest;
	logic [255:0] irqEvent;
	logic [15:0]  periphIndirectAddr;
	logic         memValid;
	logic         memWrite;
	logic         memByte;
	logic [15:0]  memAddr;
	logic [15:0]  memWdata;
	logic         memReady;
	logic [15:0]  memRdata;
	logic [3:0]   blockIrq;
	logic [1:0]   slow;
	logic [15:0]  q;
	int           fail_count = 0;
	int           compares = 0;
	int           irqCnt [4] = '{0, 0, 0, 0};
	logic [7:0]   codes [4] = '{8'h00, 8'h07, 8'h0b, 8'h0c};

	fdc_dma_ctrl fdc_dma_ctrl_i (.clk_sys(clk_sys), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irqEvent(irqEvent),
		.periphIndirectAddr(periphIndirectAddr), .memValid(memValid),
		.memWrite(memWrite), .memByte(memByte), .memAddr(memAddr),
		.memWdata(memWdata), .memReady(memReady), .memRdata(memRdata),
		.blockIrq(blockIrq));
	fdc_mem_model fdc_mem_model_i (.clk_sys(clk_sys), .reset_n(reset_n),
		.memValid(memValid), .memWrite(memWrite), .memByte(memByte),
		.memAddr(memAddr), .memWdata(memWdata), .memReady(memReady),
		.memRdata(memRdata), .slow(slow));

	always #4 clk_sys = ~clk_sys;
	// pulses are one cycle wide, so count them as they pass
	always @(posedge clk_sys)
		for (int i = 0; i < 4; i++)
			if (blockIrq[i] === 1'b1)
				irqCnt[i]++;

	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] s, e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	// hold the request until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [15:0] d, output logic [15:0] r);
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {16'h0000, d};
		// sampled at the edge itself, before the design's registers move
		do
			@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0);
		r = avs_readdata[15:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] r;
		bus(1'b1, a, d, r);
	endtask

	function automatic logic [7:0] ra(input logic [1:0] c,
		input logic [2:0] g);
		return {1'b0, c, g, 2'b00};
	endfunction

	task automatic idle();
		for (int n = 0; n < 40; n++) begin
			bus(1'b0, 8'h84, 16'h0000, q);
			// ping buffer bits may stay set once idle
			if (q[8] === 1'b0 && q[3:0] === 4'h0)
				break;
		end
	endtask

	// control goes last: address and count only change while off
	task automatic cfg(input logic [1:0] c, input logic [15:0] ctl,
		input logic [15:0] ram, pad, cnt);
		wr(ra(c, fdc_pkg::REG_SEL), 16'h00ff);
		wr(ra(c, fdc_pkg::REG_RAMA), ram);
		wr(ra(c, fdc_pkg::REG_PAD), pad);
		wr(ra(c, fdc_pkg::REG_CNT), cnt);
		wr(ra(c, fdc_pkg::REG_CTL), ctl);
	endtask

	task automatic go(input logic [3:0] m);
		wr(8'h80, {12'h000, m});
		idle();
	endtask

	task automatic ev(input logic [7:0] c);
		@(posedge clk_sys);
		irqEvent[c] <= 1'b1;
		@(posedge clk_sys);
		irqEvent <= '0;
		idle();
	endtask

	task automatic poke(input logic [15:0] a, d);
		fdc_mem_model_i.mem[a[12:1]] = d;
	endtask

	function automatic logic [15:0] peek(input logic [15:0] a);
		return fdc_mem_model_i.mem[a[12:1]];
	endfunction

	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		close_out();
	end

	initial begin
		reset_n = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		irqEvent = '0;
		periphIndirectAddr = 16'h0000;
		slow = 2'h0;
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		bus(1'b0, ra(3, fdc_pkg::REG_PAD), 16'h0, q);
		chk("pad reset", q, 16'h0000);
		wr(ra(3, fdc_pkg::REG_PAD), 16'hffff);
		bus(1'b0, ra(3, fdc_pkg::REG_PAD), 16'h0, q);
		chk("pad rw", q, 16'hffff);
		wr(ra(3, fdc_pkg::REG_CNT), 16'hffff);
		bus(1'b0, ra(3, fdc_pkg::REG_CNT), 16'h0, q);
		chk("cnt top bits", q, 16'h3fff);
		bus(1'b0, 8'h18, 16'h0, q);
		chk("unmapped", q, 16'h0000);
		$display("test registers done");
		for (int i = 0; i < 3; i++)
			poke(16'h0100 + 16'(2 * i), 16'h1000 + 16'(i));
		cfg(0, 16'ha000, 16'h0100, 16'h0224, 16'h0002);
		for (int i = 0; i < 3; i++) begin
			go(4'h1);
			chk("word out", peek(16'h0224), 16'h1000 + 16'(i));
			chk("full irq", 16'(irqCnt[0]), 16'(i == 2));
		end
		wr(ra(0, fdc_pkg::REG_CTL), 16'h0000);
		$display("test full block done");
		cfg(1, 16'hb000, 16'h0100, 16'h0226, 16'h0003);
		for (int i = 0; i < 4; i++) begin
			go(4'h2);
			chk("half irq", 16'(irqCnt[1]), 16'(i >= 1));
		end
		wr(ra(1, fdc_pkg::REG_CTL), 16'h0000);
		$display("test half block done");
		cfg(2, 16'hc810, 16'h0200, 16'h0226, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			poke(16'h0200, 16'h5500);
			poke(16'h0226, 16'h1230 + 16'(i));
			wr(ra(2, fdc_pkg::REG_SEL), {8'h00, codes[i]});
			ev(codes[i]);
			chk("byte in", peek(16'h0200), 16'h5530 + 16'(i));
			chk("null write", peek(16'h0226), 16'h1200);
		end
		wr(ra(2, fdc_pkg::REG_CTL), 16'h0000);
		$display("test events done");
		cfg(0, 16'ha000, 16'h0100, 16'h0400, 16'h0000);
		cfg(1, 16'ha000, 16'h0100, 16'h0402, 16'h0000);
		slow <= 2'h2;
		fdc_mem_model_i.wrLog.delete();
		go(4'h3);
		chk("first grant", fdc_mem_model_i.wrLog[0], 16'h0400);
		chk("second grant", fdc_mem_model_i.wrLog[1], 16'h0402);
		slow <= 2'h0;
		wr(ra(0, fdc_pkg::REG_CTL), 16'h0000);
		wr(ra(1, fdc_pkg::REG_CTL), 16'h0000);
		$display("test priority done");
		poke(16'h0226, 16'h7777);
		periphIndirectAddr <= 16'h0300;
		cfg(3, 16'h8020, 16'h0000, 16'h0226, 16'h0000);
		go(4'h8);
		chk("indirect", peek(16'h0300), 16'h7777);
		wr(ra(3, fdc_pkg::REG_CTL), 16'h0000);
		$display("test indirect done");
		poke(16'h0500, 16'h00a5);
		poke(16'h0600, 16'h005a);
		wr(ra(0, fdc_pkg::REG_RAMB), 16'h0600);
		cfg(0, 16'ha003, 16'h0500, 16'h0224, 16'h0000);
		go(4'h1);
		chk("ping A", peek(16'h0224), 16'h00a5);
		go(4'h1);
		chk("ping B", peek(16'h0224), 16'h005a);
		bus(1'b0, ra(0, fdc_pkg::REG_CTL), 16'h0, q);
		chk("one-shot off", {15'h0, q[15]}, 16'h0000);
		go(4'h1);
		chk("off ignores", peek(16'h0224), 16'h005a);
		$display("test ping-pong done");
		close_out();
	end
endmodule
`default_nettype wire
